// ### hdl/gdig_pkg.sv
package gdig_pkg;
  // serial word layout: [7:6] command, [5:0] payload
  localparam int unsigned WORD_W        = 8;
  localparam int unsigned CMD_MSB       = 7;
  localparam int unsigned CMD_LSB       = 6;
  localparam int unsigned DT_W          = 6;
  localparam logic [1:0]  CMD_DEADTIME  = 2'h1;
  localparam logic [1:0]  CMD_SIMUL     = 2'h2;
  localparam logic [5:0]  SIMUL_KEY     = 6'h2A;
  localparam logic [5:0]  DT_RST        = 6'h04;
  localparam logic        SIMUL_RST     = 1'b0;
  localparam logic [2:0]  BITCNT_RST    = 3'h0;
  // dead time counts steps of 40 ns, two core cycles of 20 ns
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned DT_STEP_NS    = 40;
  localparam int unsigned DT_STEP_CYC   = (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gdig_gate_s;

  typedef struct packed {
    logic [DT_W-1:0] dead_time;
    logic            simul_ok;
  } gdig_cfg_s;
endpackage

// ### hdl/gdig_top.sv
`timescale 1ns/100ps
module gdig_top
  import gdig_pkg::*;
(
  // clocks and reset
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       sclk_i,
  // enables and phase commands
  input  wire logic       gate_enable_first_i,
  input  wire logic       gate_enable_second_i,
  input  wire logic       phase_a_high_cmd_n_i,
  input  wire logic       phase_a_low_cmd_i,
  input  wire logic       phase_b_high_cmd_n_i,
  input  wire logic       phase_b_low_cmd_i,
  input  wire logic       phase_c_high_cmd_n_i,
  input  wire logic       phase_c_low_cmd_i,
  // comparator results (source above half load supply)
  input  wire logic [2:0] src_above_half_i,
  // serial port
  input  wire logic       cs_n_i,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  // gate drives and status
  output logic [2:0]      gate_high_o,
  output logic [2:0]      gate_low_o,
  output logic            switch_node_a_state_o,
  output logic            switch_node_b_state_o,
  output logic            switch_node_c_state_o
);

  // ---------------- serial clock domain ----------------
  logic [WORD_W-1:0] shift_ff;
  logic [2:0]        bitcnt_ff;
  logic [WORD_W-1:0] word_ff;
  logic              word_tgl_ff;
  logic              sdo_ff;

  // capture on falling edge, msb first; cs high clears the frame
  // a word cut short by chip select is dropped once a falling serial edge comes with cs high, which restarts the count at zero
  always_ff @(negedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_ff    <= '0;
      bitcnt_ff   <= BITCNT_RST;
      word_ff     <= '0;
      word_tgl_ff <= 1'b0;
    end else if (cs_n_i) begin
      bitcnt_ff <= BITCNT_RST;
    end else begin
      shift_ff  <= {shift_ff[WORD_W-2:0], sdi_i};
      bitcnt_ff <= bitcnt_ff + 3'h1;
      if (bitcnt_ff == 3'h7) begin
        word_ff     <= {shift_ff[WORD_W-2:0], sdi_i};
        word_tgl_ff <= ~word_tgl_ff;
      end
    end
  end

  // echo previous word on rising edge so the master samples on falling
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sdo_ff <= 1'b0;
    end else begin
      sdo_ff <= shift_ff[WORD_W-1];
    end
  end

  // ---------------- core domain: synchronisers ----------------
  logic [9:0] pin_s1_ff;
  logic [9:0] pin_s2_ff;
  logic [2:0] cmp_s1_ff;
  logic [2:0] cmp_s2_ff;
  logic [2:0] tgl_sync_ff;

  // every gate and comparator pin passes two flops before any core logic looks at it
  // field order puts phase a lowest in each group, at bits 5 and 2, so it lines up with the gate outputs
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_ff <= 10'h000;
      pin_s2_ff <= 10'h000;
      cmp_s1_ff <= 3'h0;
      cmp_s2_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {gate_enable_first_i, gate_enable_second_i,
                    phase_c_high_cmd_n_i, phase_b_high_cmd_n_i, phase_a_high_cmd_n_i,
                    phase_c_low_cmd_i, phase_b_low_cmd_i, phase_a_low_cmd_i,
                    2'h0};
      pin_s2_ff <= pin_s1_ff;
      cmp_s1_ff <= src_above_half_i;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // word toggle crosses into the core clock; the word itself waits in word_ff
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tgl_sync_ff <= 3'h0;
    end else begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], word_tgl_ff};
    end
  end

  // word_ff is stable for many core cycles after its toggle lands
  logic word_evt;
  assign word_evt = tgl_sync_ff[2] ^ tgl_sync_ff[1];

  // ---------------- configuration ----------------
  gdig_cfg_s cfg_ff;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_ff.dead_time <= DT_RST;
      cfg_ff.simul_ok  <= SIMUL_RST;
    end else if (word_evt) begin
      if (word_ff[CMD_MSB:CMD_LSB] == CMD_DEADTIME) begin
        cfg_ff.dead_time <= word_ff[DT_W-1:0];
      end else if (word_ff[CMD_MSB:CMD_LSB] == CMD_SIMUL) begin
        // only the exact key arms it; anything else disarms
        cfg_ff.simul_ok <= (word_ff[DT_W-1:0] == SIMUL_KEY);
      end
    end
  end

  // ---------------- gate decision ----------------
  gdig_gate_s req;
  logic       enable_both;
  assign enable_both = pin_s2_ff[9] & pin_s2_ff[8];
  assign req.high    = ~pin_s2_ff[7:5];
  assign req.low     = pin_s2_ff[4:2];

  gdig_gate_s gate_ff;
  logic [2:0] high_last_ff;
  logic [2:0] low_last_ff;
  logic [7:0] dt_cnt_ff [3];

  // dead time: unless the safe command lets both on, a side turns on only after the other has been off long enough
  // a dead time of zero swaps sides in one cycle with no gap at all
  function automatic logic [7:0] dt_cycles(input logic [DT_W-1:0] dt);
    dt_cycles = 8'({2'h0, dt} * DT_STEP_CYC);
  endfunction

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_ff.high <= 3'h0;
      gate_ff.low  <= 3'h0;
      high_last_ff <= 3'h0;
      low_last_ff  <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        dt_cnt_ff[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!enable_both) begin
          gate_ff.high[i] <= 1'b0;
          gate_ff.low[i]  <= 1'b0;
          dt_cnt_ff[i]    <= dt_cycles(cfg_ff.dead_time);
        end else if (req.high[i] && req.low[i] && cfg_ff.simul_ok) begin
          gate_ff.high[i] <= 1'b1;
          gate_ff.low[i]  <= 1'b1;
        end else if (req.high[i] && !req.low[i]) begin
          gate_ff.low[i] <= 1'b0;
          if (gate_ff.low[i] || !high_last_ff[i]) begin
            dt_cnt_ff[i]    <= dt_cycles(cfg_ff.dead_time);
            high_last_ff[i] <= 1'b1;
            low_last_ff[i]  <= 1'b0;
            gate_ff.high[i] <= (cfg_ff.dead_time == '0);
          end else if (dt_cnt_ff[i] > 8'h01) begin
            dt_cnt_ff[i] <= dt_cnt_ff[i] - 8'h01;
          end else begin
            gate_ff.high[i] <= 1'b1;
          end
        end else if (req.low[i] && !req.high[i]) begin
          gate_ff.high[i] <= 1'b0;
          if (gate_ff.high[i] || !low_last_ff[i]) begin
            dt_cnt_ff[i]    <= dt_cycles(cfg_ff.dead_time);
            low_last_ff[i]  <= 1'b1;
            high_last_ff[i] <= 1'b0;
            gate_ff.low[i]  <= (cfg_ff.dead_time == '0);
          end else if (dt_cnt_ff[i] > 8'h01) begin
            dt_cnt_ff[i] <= dt_cnt_ff[i] - 8'h01;
          end else begin
            gate_ff.low[i] <= 1'b1;
          end
        end else begin
          // both off, or both requested without the safe command
          gate_ff.high[i] <= 1'b0;
          gate_ff.low[i]  <= 1'b0;
          high_last_ff[i] <= 1'b0;
          low_last_ff[i]  <= 1'b0;
        end
      end
    end
  end

  assign gate_high_o = gate_ff.high;
  assign gate_low_o  = gate_ff.low;

  // status follows the synchronised comparator result
  logic [2:0] status_ff;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_ff <= 3'h0;
    end else begin
      status_ff <= cmp_s2_ff;
    end
  end
  assign switch_node_a_state_o = status_ff[0];
  assign switch_node_b_state_o = status_ff[1];
  assign switch_node_c_state_o = status_ff[2];

  // output enable direct from cs so the pin releases without a serial edge
  logic oe_ff;
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_ff <= 1'b0;
    end else if (cs_n_i) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= 1'b1;
    end
  end
  assign sdo_o    = sdo_ff;
  // the flop clears at once on chip select, so the pin needs no gate after it
  assign sdo_oe_o = oe_ff;

  // ---------------- assertions ----------------
  a_gate_enable_gating: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !$past(enable_both) |-> (gate_ff.high == 3'h0 && gate_ff.low == 3'h0))
    else $error("gate on without both enables");

  a_no_shoot_through: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((gate_ff.high & gate_ff.low) != 3'h0) |-> $past(cfg_ff.simul_ok))
    else $error("simultaneous drive without safe command");

  a_high_active_low: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (gate_ff.high[0] && !gate_ff.low[0]) |-> !$past(pin_s2_ff[5]))
    else $error("high side on while its command is high");

  a_low_active_high: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (gate_ff.low[0] && !gate_ff.high[0]) |-> $past(pin_s2_ff[2]))
    else $error("low side on while its command is low");

  a_status_follow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    status_ff == $past(cmp_s2_ff))
    else $error("phase status lags its comparator");

  a_sdo_release: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    cs_n_i |-> !sdo_oe_o)
    else $error("serial output driven while deselected");

  a_frame_reset: assert property (@(negedge sclk_i) disable iff (!arst_n_i)
    cs_n_i |=> (bitcnt_ff == BITCNT_RST))
    else $error("bit count kept outside frame");

  a_msb_first: assert property (@(negedge sclk_i) disable iff (!arst_n_i)
    !cs_n_i |=> (shift_ff[0] == $past(sdi_i)))
    else $error("serial bit not captured");

  a_oe_in_frame: assert property (@(negedge sclk_i) disable iff (!arst_n_i)
    !cs_n_i |-> sdo_oe_o)
    else $error("serial output idle inside frame");

  // a config word of each kind, as seen in the core domain
  sequence s_dt_word;
    word_evt && (word_ff[CMD_MSB:CMD_LSB] == CMD_DEADTIME);
  endsequence

  sequence s_simul_word;
    word_evt && (word_ff[CMD_MSB:CMD_LSB] == CMD_SIMUL);
  endsequence

  a_dt_program: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    s_dt_word |=> (cfg_ff.dead_time == $past(word_ff[DT_W-1:0])))
    else $error("dead time not taken from its command");

  a_simul_key: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    s_simul_word |=> (cfg_ff.simul_ok == ($past(word_ff[DT_W-1:0]) == SIMUL_KEY)))
    else $error("safe command key not applied");

  // a lone side request never lights the other side
  a_low_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (!$past(req.high[0]) && $past(req.low[0])) |-> !gate_ff.high[0])
    else $error("high side on without its command");

  a_high_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ($past(req.high[0]) && !$past(req.low[0])) |-> !gate_ff.low[0])
    else $error("low side on without its command");

endmodule

// ### dv/gdig_mcu_model.sv
`timescale 1ns/100ps
// controller side of the serial port
module gdig_mcu_model (
  // serial port toward the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  // serial clock stands still low outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // one framed word, msb first, 160 ns bit time
  task automatic send_word(input logic [7:0] w);
    cs_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #80;
      sclk_o = 1'b1;
      sdi_o  = w[i];
      #80;
      sclk_o = 1'b0;
    end
    #80;
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o; // released line must not look held
  endtask
endmodule

// ### dv/gate_drive_input_gating_tb.sv
`timescale 1ns/100ps
module gate_drive_input_gating_tb;
  logic       core_clk_i = 1'b0;
  logic       arst_n_i   = 1'b0;
  logic [1:0] en         = 2'h0;
  logic [2:0] hi_n       = 3'h7;
  logic [2:0] lo         = 3'h0;
  logic [2:0] src        = 3'h0;
  logic       sclk, cs_n, sdi, sdo, sdo_oe;
  logic [2:0] g_hi, g_lo, node;
  int         errors     = 0;
  int         check_count = 0;
  logic [7:0] echo       = 8'h00;

  always #10 core_clk_i = ~core_clk_i;

  gdig_top gdig_top_i (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk),
    .gate_enable_first_i(en[0]), .gate_enable_second_i(en[1]),
    .phase_a_high_cmd_n_i(hi_n[0]), .phase_a_low_cmd_i(lo[0]),
    .phase_b_high_cmd_n_i(hi_n[1]), .phase_b_low_cmd_i(lo[1]),
    .phase_c_high_cmd_n_i(hi_n[2]), .phase_c_low_cmd_i(lo[2]),
    .src_above_half_i(src), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .gate_high_o(g_hi), .gate_low_o(g_lo), .switch_node_a_state_o(node[0]),
    .switch_node_b_state_o(node[1]), .switch_node_c_state_o(node[2]));

  gdig_mcu_model gdig_mcu_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // drive pins on an edge, then let n edges pass
  task automatic drive(input logic [1:0] e, input logic [2:0] h, input logic [2:0] l,
                       input int n);
    @(posedge core_clk_i);
    en   <= e;
    hi_n <= h;
    lo   <= l;
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // word then settle margin for the crossing into the core domain
  task automatic word(input logic [7:0] w);
    gdig_mcu_model_i.send_word(w);
    repeat (6) @(posedge core_clk_i);
  endtask

  // output enable watched on every falling serial edge and every idle falling core edge
  // idle check on the falling core edge, clear of frame edges on the rising one
  always @(negedge sclk) if (!cs_n) check({7'h00, sdo_oe}, 8'h01);
  always @(negedge core_clk_i) if (cs_n) check({7'h00, sdo_oe}, 8'h00);
  // collect what the device echoes, on the edge the master samples
  always @(negedge sclk) if (!cs_n) echo <= {echo[6:0], sdo};

  task automatic t_defaults;
    drive(2'h3, 3'h6, 3'h0, 20);
    check({2'h0, g_hi, g_lo}, 8'h08);
    drive(2'h3, 3'h7, 3'h1, 6);
    check({2'h0, g_hi, g_lo}, 8'h00);
    repeat (10) @(posedge core_clk_i);
    check({2'h0, g_hi, g_lo}, 8'h01);
    drive(2'h3, 3'h6, 3'h1, 20);
    check({2'h0, g_hi, g_lo}, 8'h00);
    $display("test defaults done");
  endtask

  task automatic t_simul;
    word(8'h40);
    word(8'hAA);
    check(echo, 8'h40);
    drive(2'h3, 3'h6, 3'h1, 8);
    check({2'h0, g_hi, g_lo}, 8'h09);
    word(8'hAB);
    check({2'h0, g_hi, g_lo}, 8'h00);
    $display("test simultaneous done");
  endtask

  task automatic t_sides;
    for (int e = 0; e < 4; e++) begin
      drive(e[1:0], 3'h5, 3'h4, 8);
      check({2'h0, g_hi, g_lo}, (e == 3) ? 8'h14 : 8'h00);
    end
    $display("test enables done");
  endtask

  task automatic t_dead;
    word(8'h4A);
    drive(2'h3, 3'h6, 3'h0, 30);
    check({2'h0, g_hi, g_lo}, 8'h08);
    drive(2'h3, 3'h7, 3'h1, 14);
    check({2'h0, g_hi, g_lo}, 8'h00);
    repeat (16) @(posedge core_clk_i);
    check({2'h0, g_hi, g_lo}, 8'h01);
    $display("test dead time done");
  endtask

  task automatic t_node;
    @(posedge core_clk_i);
    src <= 3'h5;
    repeat (6) @(posedge core_clk_i);
    check({5'h00, node}, 8'h05);
    src <= 3'h2;
    repeat (6) @(posedge core_clk_i);
    check({5'h00, node}, 8'h02);
    $display("test status done");
  endtask

  // reset in mid-run must drop gates at once and forget the unlock
  task automatic t_rst2;
    word(8'hAA);
    drive(2'h3, 3'h6, 3'h1, 8);
    arst_n_i <= 1'b0;
    #2;
    check({2'h0, g_hi, g_lo}, 8'h00);
    repeat (3) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    check({2'h0, g_hi, g_lo}, 8'h00);
    $display("test second reset done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard well beyond the whole sequence
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end

  initial begin
    drive(2'h3, 3'h6, 3'h0, 15);
    check({2'h0, g_hi, g_lo}, 8'h00);
    arst_n_i <= 1'b1;
    t_defaults();
    t_simul();
    t_sides();
    t_dead();
    t_node();
    t_rst2();
    print_verdict();
  end
endmodule
